// ===== ptg_generator.sv
// Tone and pulse width generator with register port and one tri-state output pin
`timescale 1ns/1ps
`default_nettype none
module ptg_generator (
  input wire logic core_clk,
  input wire logic reset,
  input wire ptg_pkg::ptg_bus_req_t bus_req,
  output logic [7:0] rdata,
  output ptg_pkg::ptg_pin_t pin
);
  import ptg_pkg::*;

  logic [7:0] config_reg, config_next;
  logic [15:0] period_reg, period_next;
  logic [15:0] duty_reg, duty_next;
  logic [7:0] microsecond_divider_div_reg, microsecond_divider_div_next;
  logic [1:0] pin_ctrl_reg, pin_ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] div_cnt_reg, div_cnt_next;
  logic tick;
  logic [15:0] cnt_reg, cnt_next;
  logic phase_reg, phase_next;
  logic [15:0] act_period_reg, act_period_next;
  logic [15:0] act_duty_reg, act_duty_next;
  logic out_reg, out_next;
  logic oe_reg, oe_next;
  logic [2:0] func;
  logic active;
  logic [16:0] quarter_start;
  logic [17:0] period_x3;

  assign func = config_reg[PTG_FUNC_LSB +: 3];
  assign active = config_reg[PTG_FUNC_LSB] && !pin_ctrl_reg[PTG_PIN_PDOWN_BIT];

  // Register port; the window follows the select bit at the time of each access
  always_comb begin
    config_next = config_reg;
    period_next = period_reg;
    duty_next = duty_reg;
    microsecond_divider_div_next = microsecond_divider_div_reg;
    pin_ctrl_next = pin_ctrl_reg;
    rdata_next = 8'h00;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        PTG_CONFIG_ADDR: config_next = bus_req.wdata & PTG_CONFIG_MASK;
        PTG_VALUE_LOW_ADDR: begin
          if (config_reg[PTG_SEL_BIT]) begin
            duty_next[7:0] = bus_req.wdata;
          end else begin
            period_next[7:0] = bus_req.wdata;
          end
        end
        PTG_VALUE_HIGH_ADDR: begin
          if (config_reg[PTG_SEL_BIT]) begin
            duty_next[15:8] = bus_req.wdata;
          end else begin
            period_next[15:8] = bus_req.wdata;
          end
        end
        PTG_MICROSECOND_DIVIDER_DIV_ADDR: microsecond_divider_div_next = bus_req.wdata;
        PTG_PIN_CTRL_ADDR: pin_ctrl_next = bus_req.wdata[1:0];
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        PTG_CONFIG_ADDR: rdata_next = config_reg;
        PTG_VALUE_LOW_ADDR: rdata_next = config_reg[PTG_SEL_BIT] ? duty_reg[7:0] : period_reg[7:0];
        PTG_VALUE_HIGH_ADDR: rdata_next = config_reg[PTG_SEL_BIT] ? duty_reg[15:8] : period_reg[15:8];
        PTG_MICROSECOND_DIVIDER_DIV_ADDR: rdata_next = microsecond_divider_div_reg;
        PTG_PIN_CTRL_ADDR: rdata_next = {6'h00, pin_ctrl_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      config_reg <= PTG_CONFIG_RESET;
      period_reg <= PTG_PERIOD_RESET;
      duty_reg <= PTG_DUTY_RESET;
      microsecond_divider_div_reg <= PTG_MICROSECOND_DIVIDER_DIV_RESET;
      pin_ctrl_reg <= PTG_PIN_CTRL_RESET;
      rdata_reg <= 8'h00;
    end else begin
      config_reg <= config_next;
      period_reg <= period_next;
      duty_reg <= duty_next;
      microsecond_divider_div_reg <= microsecond_divider_div_next;
      pin_ctrl_reg <= pin_ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  // Microsecond divider: one tick every divider value plus one clocks
  always_comb begin
    div_cnt_next = div_cnt_reg + 8'h01;
    if (div_cnt_reg >= microsecond_divider_div_reg) begin
      div_cnt_next = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_cnt_reg <= 8'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  assign tick = config_reg[PTG_SPD_BIT] || (div_cnt_reg >= microsecond_divider_div_reg);

  // Staircase goes high-z once three quarters of a half period have elapsed
  // Three times a full 16-bit period needs 18 bits before the divide by four
  assign period_x3 = {2'b00, act_period_reg} * 18'd3;
  assign quarter_start = {1'b0, period_x3[17:2]};

  // Waveform engine; while running, period and duty are sampled only at a cycle boundary, and while off they follow the registers every clock
  always_comb begin
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    act_period_next = act_period_reg;
    act_duty_next = act_duty_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    if (!active) begin
      cnt_next = 16'h0000;
      phase_next = 1'b0;
      act_period_next = period_reg;
      act_duty_next = duty_reg;
      oe_next = 1'b0;
      out_next = 1'b1;
    end else begin
      if (tick && func[1]) begin
        // two half periods of the period value each
        if (cnt_reg + 16'h0001 >= act_period_reg) begin
          cnt_next = 16'h0000;
          phase_next = !phase_reg;
          if (phase_reg) begin
            act_period_next = period_reg;
          end
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end else if (tick) begin
        // cycle of period plus one ticks
        if (cnt_reg >= act_period_reg) begin
          cnt_next = 16'h0000;
          act_period_next = period_reg;
          act_duty_next = duty_reg;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      // Levels follow the count on every clock, so enabling drives the pin at once rather than one tick late
      if (func[1]) begin
        out_next = !phase_next;
        oe_next = 1'b1;
        if (func[2] && ({1'b0, cnt_next} >= quarter_start) && cnt_next != 16'h0000) begin
          oe_next = 1'b0;
        end
      end else begin
        // duty zero and duty above period fall out of the compare
        out_next = (cnt_next < act_duty_next) ^ config_reg[PTG_POL_BIT];
        oe_next = 1'b1;
      end
    end
    if (!pin_ctrl_reg[PTG_PIN_LATCH_BIT]) begin
      oe_next = 1'b1;
      out_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cnt_reg <= 16'h0000;
      phase_reg <= 1'b0;
      act_period_reg <= PTG_PERIOD_RESET;
      act_duty_reg <= PTG_DUTY_RESET;
      out_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      act_period_reg <= act_period_next;
      act_duty_reg <= act_duty_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign rdata = rdata_reg;
  assign pin.pin_out = out_reg;
  assign pin.pin_oe = oe_reg;
endmodule
`default_nettype wire

// ===== ptg_pkg.sv
// Package with register map, field positions and constants of the tone and pulse generator
// Notes on behaviour
// - Polarity bit: duty sets high or low time
// - Select bit routes window to period/duty
// - Tick source: microsecond tick or system clock
// - Function field picks off, PWM, square, staircase
// - Function bit0 zero disables; config resets zero
// - Bit1 zero PWM, one tone
// - Staircase uses low, high-z, high levels
// - Square tone is two-level half duty
// - Staircase high-z for last quarter half-period
// - Tone period is twice period value ticks
// - Selected tick clocks period and duty counts
// - PWM cycle period plus one; high duty ticks
// - Polarity one: duty sets low time
// - Polarity zero: duty 0 low, above period high
// - Polarity one: duty 0 high, above period low
// - Low/high bytes form one 16-bit window
// - Output reaches pin only when latch is one
// - Power-down bit stops the generator
package ptg_pkg;
  localparam logic [7:0] PTG_CONFIG_ADDR = 8'ha1;
  localparam logic [7:0] PTG_VALUE_LOW_ADDR = 8'ha2;
  localparam logic [7:0] PTG_VALUE_HIGH_ADDR = 8'ha3;
  localparam logic [7:0] PTG_MICROSECOND_DIVIDER_DIV_ADDR = 8'ha4;
  localparam logic [7:0] PTG_PIN_CTRL_ADDR = 8'ha5;
  localparam int PTG_POL_BIT = 5;
  localparam int PTG_SEL_BIT = 4;
  localparam int PTG_SPD_BIT = 3;
  localparam int PTG_FUNC_LSB = 0;
  localparam int PTG_PIN_LATCH_BIT = 0;
  localparam int PTG_PIN_PDOWN_BIT = 1;
  localparam logic [7:0] PTG_CONFIG_RESET = 8'h00;
  localparam logic [7:0] PTG_CONFIG_MASK = 8'h3f;
  localparam logic [15:0] PTG_PERIOD_RESET = 16'h0000;
  localparam logic [15:0] PTG_DUTY_RESET = 16'h0000;
  localparam logic [7:0] PTG_MICROSECOND_DIVIDER_DIV_RESET = 8'h00;
  localparam logic [1:0] PTG_PIN_CTRL_RESET = 2'h1;

  typedef enum logic [2:0] {
    PTG_FUNC_OFF = 3'b000,
    PTG_FUNC_PWM = 3'b001,
    PTG_FUNC_SQUARE = 3'b011,
    PTG_FUNC_STAIR = 3'b111
  } ptg_func_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptg_bus_req_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } ptg_pin_t;
endpackage

// ===== ptg_assertions.sv
// Checker for the generator's register port and pin
`timescale 1ns/1ps
`default_nettype none
module ptg_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire ptg_pkg::ptg_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire ptg_pkg::ptg_pin_t pin
);
  import ptg_pkg::*;
  logic [7:0] cfg_reg;
  logic [1:0] pc_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Shadows follow the design's own write timing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_reg <= 8'h00;
      pc_reg <= 2'h1;
    end else if (bus_req.wr && bus_req.addr == 8'ha1) begin
      cfg_reg <= bus_req.wdata & 8'h3f;
    end else if (bus_req.wr && bus_req.addr == 8'ha5) begin
      pc_reg <= bus_req.wdata[1:0];
    end
  end
  sequence s_cfg_wr; bus_req.wr && bus_req.addr == 8'ha1; endsequence
  sequence s_cfg_rd; bus_req.rd && bus_req.addr == 8'ha1; endsequence
  AST_WR_RD: assert property (s_cfg_wr ##1 s_cfg_rd |=> rdata == ($past(bus_req.wdata, 2) & 8'h3f))
    else $error("config readback");
  AST_CFG_RD: assert property (s_cfg_rd |=> rdata == $past(cfg_reg)) else $error("config read");
  AST_RST: assert property (disable iff (1'b0) reset |=> !pin.pin_oe && pin.pin_out && rdata == 8'h00)
    else $error("reset state");
  AST_RD_IDLE: assert property (!bus_req.rd |=> rdata == 8'h00) else $error("stray read data");
  AST_OFF: assert property ($past(!cfg_reg[0] && pc_reg[0]) |-> !pin.pin_oe) else $error("off but driven");
  AST_PDOWN: assert property ($past(pc_reg == 2'h3) |-> !pin.pin_oe) else $error("powered down but driven");
  AST_LATCH: assert property ($past(cfg_reg[0] && pc_reg == 2'h0) |-> pin.pin_oe && !pin.pin_out)
    else $error("latch low ignored");
  AST_DRIVEN: assert property ($past(cfg_reg[0] && !cfg_reg[2] && pc_reg == 2'h1) |-> pin.pin_oe)
    else $error("two-level mode released");
endmodule
`default_nettype wire

// ===== ptg_load.sv
// Speaker buffer load on the generator pin
`timescale 1ns/1ps
`default_nettype none
module ptg_load (
  input wire ptg_pkg::ptg_pin_t pin,
  output logic [1:0] level
);
  import ptg_pkg::*;
  // Released pin sits at mid supply through the buffer: 0 low, 1 mid, 2 high
  // The pin is taken as set up for output; a pin in input mode would never reach the buffer
  assign level = !pin.pin_oe ? 2'h1 : (pin.pin_out ? 2'h2 : 2'h0);
endmodule
`default_nettype wire

// ===== test_pwm_tone_generator.sv
// Self-checking bench for the tone and pulse generator
`timescale 1ns/1ps
`default_nettype none
module test_pwm_tone_generator;
  import ptg_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  ptg_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  ptg_pin_t pin;
  logic [1:0] level;
  int n_errors = 0;
  int num_checks = 0;
  always #20 core_clk = ~core_clk;
  ptg_generator u_ptg_generator (.core_clk(core_clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .pin(pin));
  ptg_load u_ptg_load (.pin(pin), .level(level));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    check({8'h00, rdata}, {8'h00, e});
  endtask
  // Write then read with no idle cycle between the strobes
  task wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    check({8'h00, rdata}, {8'h00, e});
  endtask
  // Duty first with the generator off, then period, as software must
  task run(input logic [7:0] c, p, d, input logic [15:0] eh, em, er);
    logic [15:0] hi;
    logic [15:0] mid;
    logic [15:0] rise;
    logic [1:0] prev;
    wr(8'ha1, 8'h10);
    wr(8'ha2, d);
    wr(8'ha3, 8'h00);
    wr(8'ha1, c);
    wr(8'ha2, p);
    wr(8'ha3, 8'h00);
    hi = 16'h0;
    mid = 16'h0;
    rise = 16'h0;
    // Settle past the old period's boundary before counting
    repeat (40) @(posedge core_clk);
    @(negedge core_clk);
    prev = level;
    repeat (60) begin
      @(negedge core_clk);
      if (level == 2'h2) hi++;
      if (level == 2'h1) mid++;
      if (level == 2'h2 && prev != 2'h2) rise++;
      prev = level;
    end
    check(hi, eh);
    check(mid, em);
    check(rise, er);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'ha1, 8'h00);
    rd(8'ha5, 8'h01);
    rd(8'h70, 8'h00);
    wr_rd(8'ha1, 8'hff, 8'h3f);
    wr(8'ha4, 8'h01);
    run(8'h09, 8'h05, 8'h02, 16'h14, 16'h0, 16'ha);
    run(8'h29, 8'h05, 8'h02, 16'h28, 16'h0, 16'ha);
    run(8'h09, 8'h05, 8'h00, 16'h0, 16'h0, 16'h0);
    run(8'h09, 8'h05, 8'h07, 16'h3c, 16'h0, 16'h0);
    run(8'h29, 8'h05, 8'h00, 16'h3c, 16'h0, 16'h0);
    run(8'h29, 8'h05, 8'h07, 16'h0, 16'h0, 16'h0);
    run(8'h0b, 8'h05, 8'h00, 16'h1e, 16'h0, 16'h6);
    run(8'h0f, 8'h05, 8'h00, 16'h12, 16'h18, 16'h6);
    run(8'h01, 8'h05, 8'h02, 16'h14, 16'h0, 16'h5);
    run(8'h00, 8'h05, 8'h00, 16'h0, 16'h3c, 16'h0);
    wr(8'ha5, 8'h00);
    run(8'h09, 8'h05, 8'h02, 16'h0, 16'h0, 16'h0);
    wr(8'ha5, 8'h03);
    run(8'h09, 8'h05, 8'h02, 16'h0, 16'h3c, 16'h0);
    wr(8'ha1, 8'h10);
    rd(8'ha2, 8'h02);
    rd(8'ha3, 8'h00);
    wr(8'ha1, 8'h00);
    rd(8'ha2, 8'h05);
    rd(8'ha4, 8'h01);
    end_sim;
  end
endmodule
bind ptg_generator ptg_assertions u_ptg_assertions (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
  .rdata(rdata), .pin(pin));
`default_nettype wire
